//--- common/vtp_defs.svh
// Register offsets, field positions, reset values and sizes of the video timing bank
`ifndef VTP_DEFS_SVH
`define VTP_DEFS_SVH
`define VTP_OFF_CHA_VSW_LO 8'h30
`define VTP_OFF_CHA_VSW_HI 8'h31
`define VTP_OFF_CHB_VSW_LO 8'h32
`define VTP_OFF_CHB_VSW_HI 8'h33
`define VTP_OFF_CHA_HBP 8'h34
`define VTP_OFF_CHB_HBP 8'h35
`define VTP_OFF_CHA_VBP 8'h36
`define VTP_OFF_CHB_VBP 8'h37
`define VTP_OFF_CHA_HFP 8'h38
`define VTP_OFF_CHB_HFP 8'h39
`define VTP_OFF_CHA_VFP 8'h3a
`define VTP_OFF_CHB_VFP 8'h3b
`define VTP_OFF_PAT_EN 8'h3c
`define VTP_OFF_SECOND_TRIM 8'h3d
`define VTP_OFF_FIRST_TRIM 8'h3e
`define VTP_OFF_CHA_HSW_LO 8'h40
`define VTP_OFF_CHA_HSW_HI 8'h41
`define VTP_OFF_CHB_HSW_LO 8'h42
`define VTP_OFF_CHB_HSW_HI 8'h43
`define VTP_OFF_CHA_ACT_LO 8'h44
`define VTP_OFF_CHA_ACT_HI 8'h45
`define VTP_OFF_CHB_ACT_LO 8'h46
`define VTP_OFF_CHB_ACT_HI 8'h47
`define VTP_OFF_CHA_LINES_LO 8'h48
`define VTP_OFF_CHA_LINES_HI 8'h49
`define VTP_OFF_CHB_LINES_LO 8'h4a
`define VTP_OFF_CHB_LINES_HI 8'h4b
`define VTP_OFF_MODE 8'h4c
`define VTP_OFF_STATUS 8'h4d
`define VTP_REG_COUNT 30
`define VTP_BIT_CHA_PAT 4
`define VTP_BIT_CHB_PAT 0
`define VTP_BIT_SINGLE_LINK 4
`define VTP_BIT_LR 0
`define VTP_LSB_CHMODE 5
`define VTP_CHMODE_INDEP 2'h2
`define VTP_REG_RESET 8'h00
`define VTP_RESP_OKAY 2'h0
`define VTP_RESP_SLVERR 2'h2
`endif

//--- common/vtp_pkg.sv
// Types shared by the video timing bank and its generators
package vtp_pkg;
  typedef enum logic [1:0] {
    VTP_SEG_SYNC = 2'b00,
    VTP_SEG_BACK = 2'b01,
    VTP_SEG_ACT = 2'b10,
    VTP_SEG_FRONT = 2'b11
  } vtp_seg_t;
  typedef struct packed {
    logic [9:0] sync;
    logic [7:0] back;
    logic [11:0] act;
    logic [7:0] front;
  } vtp_span_t;
  typedef struct packed {
    vtp_span_t h;
    vtp_span_t v;
  } vtp_timing_t;
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic de;
    logic [11:0] x;
    logic [11:0] y;
  } vtp_video_t;
endpackage

//--- verilog/vtp_gen.sv
// Sync, porch and active sequencer for one generated video channel
`timescale 1ns/10ps
`default_nettype none
module vtp_gen (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic enable,
  input wire vtp_pkg::vtp_timing_t timing,
  // Generated video
  output vtp_pkg::vtp_video_t video
);
  typedef struct packed {
    vtp_pkg::vtp_seg_t hseg;
    vtp_pkg::vtp_seg_t vseg;
    logic [11:0] hcnt;
    logic [11:0] vcnt;
    logic [11:0] x;
    logic [11:0] y;
    vtp_pkg::vtp_video_t out;
  } vtp_gen_state_t;
  vtp_gen_state_t st; // Registered state
  vtp_gen_state_t next_st; // Next state

  // Length of a segment, zero lasts one count like a length of one
  function automatic logic [11:0] seg_len(input vtp_pkg::vtp_seg_t s, input vtp_pkg::vtp_span_t p);
    case (s)
      vtp_pkg::VTP_SEG_SYNC: seg_len = {2'h0, p.sync};
      vtp_pkg::VTP_SEG_BACK: seg_len = {4'h0, p.back};
      vtp_pkg::VTP_SEG_ACT: seg_len = p.act;
      default: seg_len = {4'h0, p.front};
    endcase
  endfunction

  // Step to the next segment in sync, back, active, front order
  function automatic vtp_pkg::vtp_seg_t seg_next(input vtp_pkg::vtp_seg_t s);
    case (s)
      vtp_pkg::VTP_SEG_SYNC: seg_next = vtp_pkg::VTP_SEG_BACK;
      vtp_pkg::VTP_SEG_BACK: seg_next = vtp_pkg::VTP_SEG_ACT;
      vtp_pkg::VTP_SEG_ACT: seg_next = vtp_pkg::VTP_SEG_FRONT;
      default: seg_next = vtp_pkg::VTP_SEG_SYNC;
    endcase
  endfunction

  // Line and frame sequencing, one pixel per clock
  always_comb begin
    logic line_end;
    line_end = 1'b0;
    next_st = st;
    if (!enable) begin
      // Idle: restart at the top of a frame
      next_st = '0;
    end else begin
      next_st.hcnt = st.hcnt + 12'h001;
      if (st.hseg == vtp_pkg::VTP_SEG_ACT) begin
        next_st.x = st.x + 12'h001;
      end
      if (st.hcnt + 12'h001 >= seg_len(st.hseg, timing.h)) begin
        // Segment done, zero-length segments pass in one clock
        next_st.hseg = seg_next(st.hseg);
        next_st.hcnt = 12'h000;
        if (st.hseg == vtp_pkg::VTP_SEG_FRONT) begin
          line_end = 1'b1;
          next_st.x = 12'h000;
        end
      end
      if (line_end) begin
        next_st.vcnt = st.vcnt + 12'h001;
        if (st.vseg == vtp_pkg::VTP_SEG_ACT) begin
          next_st.y = st.y + 12'h001;
        end
        if (st.vcnt + 12'h001 >= seg_len(st.vseg, timing.v)) begin
          next_st.vseg = seg_next(st.vseg);
          next_st.vcnt = 12'h000;
          if (st.vseg == vtp_pkg::VTP_SEG_FRONT) begin
            next_st.y = 12'h000;
          end
        end
      end
    end
    // Outputs from flops, one clock behind the counters
    next_st.out.hsync = enable && st.hseg == vtp_pkg::VTP_SEG_SYNC && timing.h.sync != 10'h000;
    next_st.out.vsync = enable && st.vseg == vtp_pkg::VTP_SEG_SYNC && timing.v.sync != 10'h000;
    next_st.out.de = enable && st.hseg == vtp_pkg::VTP_SEG_ACT && st.vseg == vtp_pkg::VTP_SEG_ACT
      && timing.h.act != 12'h000;
    next_st.out.x = st.x;
    next_st.out.y = st.y;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign video = st.out;
endmodule
`default_nettype wire

//--- verilog/vtp_bank.sv
// Video timing register bank with AXI4-Lite slave, test pattern generators and line trim
`timescale 1ns/10ps
`default_nettype none
`include "vtp_defs.svh"
module vtp_bank (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [8:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [8:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Received DSI video, one pixel per clock per input
  input wire logic first_in_de,
  input wire logic second_in_de,
  // Trimmed pixel qualifiers
  output logic first_keep,
  output logic second_keep,
  // Channel A and B video towards the serializer
  output vtp_pkg::vtp_video_t cha_video,
  output vtp_pkg::vtp_video_t chb_video,
  // Timing selection seen by the serializer
  output logic chb_uses_cha_timing,
  output logic cha_pattern_active,
  output logic chb_pattern_active
);
  typedef struct packed {
    logic [`VTP_REG_COUNT-1:0][7:0] regs;
    logic aw_held;
    logic [8:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [11:0] first_pos;
    logic [11:0] second_pos;
    logic first_keep;
    logic second_keep;
  } vtp_bank_state_t;
  vtp_bank_state_t st; // Registered state
  vtp_bank_state_t next_st; // Next state
  vtp_pkg::vtp_timing_t cha_timing; // Channel A generator timing
  vtp_pkg::vtp_timing_t chb_timing; // Channel B generator timing
  vtp_pkg::vtp_video_t cha_gen; // Channel A pattern video
  vtp_pkg::vtp_video_t chb_gen; // Channel B pattern video
  logic [1:0] chmode; // Input channel mode field
  logic single_link; // Serializer single-link bit
  logic lr_mode; // Left/right pixel mode
  logic indep; // Two independent streams
  logic cha_pat_en; // Channel A pattern request
  logic chb_pat_en; // Channel B pattern request
  logic wr_go; // Both write halves present
  logic rd_go; // Read address accepted

  // Byte address to register index, out of range gives all ones
  // Byte address is four times the register offset, one word each
  function automatic logic [4:0] reg_index(input logic [8:0] addr);
    logic [7:0] off;
    off = {1'b0, addr[8:2]};
    if (addr[1:0] != 2'h0) begin
      reg_index = 5'h1f;
    end else if (off > `VTP_OFF_FIRST_TRIM && off < `VTP_OFF_CHA_HSW_LO) begin
      reg_index = 5'h1f; // Hole between the trim and hsync registers
    end else if (off >= `VTP_OFF_CHA_VSW_LO && off <= `VTP_OFF_STATUS) begin
      reg_index = 5'(off - `VTP_OFF_CHA_VSW_LO);
    end else begin
      reg_index = 5'h1f;
    end
  endfunction

  // Index of an offset inside the register array
  function automatic int idx(input logic [7:0] off);
    idx = int'(off) - int'(`VTP_OFF_CHA_VSW_LO);
  endfunction

  // Ten-bit value from a low and a high register
  function automatic logic [9:0] join10(input logic [7:0] lo, input logic [7:0] hi);
    join10 = {hi[1:0], lo};
  endfunction

  // Twelve-bit value from a low and a high register
  function automatic logic [11:0] join12(input logic [7:0] lo, input logic [7:0] hi);
    join12 = {hi[3:0], lo};
  endfunction

  // Mode bits from the control register, pattern requests from the pattern enable register
  assign chmode = st.regs[idx(`VTP_OFF_MODE)][`VTP_LSB_CHMODE +: 2];
  assign single_link = st.regs[idx(`VTP_OFF_MODE)][`VTP_BIT_SINGLE_LINK];
  assign lr_mode = st.regs[idx(`VTP_OFF_MODE)][`VTP_BIT_LR];
  assign indep = !single_link && chmode == `VTP_CHMODE_INDEP;
  assign cha_pat_en = st.regs[idx(`VTP_OFF_PAT_EN)][`VTP_BIT_CHA_PAT];
  assign chb_pat_en = st.regs[idx(`VTP_OFF_PAT_EN)][`VTP_BIT_CHB_PAT] && indep;
  assign chb_uses_cha_timing = !single_link && !indep;

  // Channel A timing fields
  always_comb begin
    cha_timing.h.sync = join10(st.regs[idx(`VTP_OFF_CHA_HSW_LO)], st.regs[idx(`VTP_OFF_CHA_HSW_HI)]);
    cha_timing.h.back = st.regs[idx(`VTP_OFF_CHA_HBP)];
    cha_timing.h.act = join12(st.regs[idx(`VTP_OFF_CHA_ACT_LO)], st.regs[idx(`VTP_OFF_CHA_ACT_HI)]);
    cha_timing.h.front = st.regs[idx(`VTP_OFF_CHA_HFP)];
    cha_timing.v.sync = join10(st.regs[idx(`VTP_OFF_CHA_VSW_LO)], st.regs[idx(`VTP_OFF_CHA_VSW_HI)]);
    cha_timing.v.back = st.regs[idx(`VTP_OFF_CHA_VBP)];
    cha_timing.v.act = join12(st.regs[idx(`VTP_OFF_CHA_LINES_LO)], st.regs[idx(`VTP_OFF_CHA_LINES_HI)]);
    cha_timing.v.front = st.regs[idx(`VTP_OFF_CHA_VFP)];
  end

  // Channel B timing fields, used only in independent mode
  always_comb begin
    chb_timing.h.sync = join10(st.regs[idx(`VTP_OFF_CHB_HSW_LO)], st.regs[idx(`VTP_OFF_CHB_HSW_HI)]);
    chb_timing.h.back = st.regs[idx(`VTP_OFF_CHB_HBP)];
    chb_timing.h.act = join12(st.regs[idx(`VTP_OFF_CHB_ACT_LO)], st.regs[idx(`VTP_OFF_CHB_ACT_HI)]);
    chb_timing.h.front = st.regs[idx(`VTP_OFF_CHB_HFP)];
    chb_timing.v.sync = join10(st.regs[idx(`VTP_OFF_CHB_VSW_LO)], st.regs[idx(`VTP_OFF_CHB_VSW_HI)]);
    chb_timing.v.back = st.regs[idx(`VTP_OFF_CHB_VBP)];
    chb_timing.v.act = join12(st.regs[idx(`VTP_OFF_CHB_LINES_LO)], st.regs[idx(`VTP_OFF_CHB_LINES_HI)]);
    chb_timing.v.front = st.regs[idx(`VTP_OFF_CHB_VFP)];
  end

  // Channel A generator, also feeds B when B follows A
  vtp_gen u_cha_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(cha_pat_en),
    .timing(cha_timing),
    .video(cha_gen)
  );

  // Channel B generator, independent mode only
  vtp_gen u_chb_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(chb_pat_en),
    .timing(chb_timing),
    .video(chb_gen)
  );

  // Video selection: B mirrors A in dual-link shared timing
  always_comb begin
    cha_video = cha_gen;
    if (chb_uses_cha_timing) begin
      chb_video = cha_gen;
    end else begin
      chb_video = chb_gen;
    end
  end
  assign cha_pattern_active = cha_pat_en;
  assign chb_pattern_active = chb_uses_cha_timing ? cha_pat_en : chb_pat_en;

  // Handshake outputs from held-request and response flags
  assign s_axi_awready = !st.aw_held;
  assign s_axi_wready = !st.w_held;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h000000, st.rdata};
  assign rd_go = s_axi_arvalid && !st.rvalid;
  assign first_keep = st.first_keep;
  assign second_keep = st.second_keep;

  // Bus slave, trim counters and register file
  always_comb begin
    logic [4:0] wi;
    logic [4:0] ri;
    logic [8:0] wa;
    logic [7:0] wd;
    logic wl;
    logic [11:0] cha_len;
    wi = 5'h1f;
    ri = 5'h1f;
    wa = 9'h000;
    wd = 8'h00;
    wl = 1'b0;
    cha_len = join12(st.regs[idx(`VTP_OFF_CHA_ACT_LO)], st.regs[idx(`VTP_OFF_CHA_ACT_HI)]);
    next_st = st;
    // Capture each write half as it arrives, in either order
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    wa = next_st.aw_addr;
    wd = next_st.w_data;
    wl = next_st.w_lane0;
    // Commit once both halves are in and no response is pending
    wr_go = next_st.aw_held && next_st.w_held && !st.bvalid;
    if (wr_go) begin
      wi = reg_index(wa);
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      if (wi == 5'h1f || wi == 5'(idx(`VTP_OFF_STATUS))) begin
        next_st.bresp = `VTP_RESP_SLVERR; // Unmapped or read-only
      end else begin
        next_st.bresp = `VTP_RESP_OKAY;
        if (wl) begin
          next_st.regs[wi] = wd;
        end
      end
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read: one cycle to answer, held until rready
    if (rd_go) begin
      ri = reg_index(s_axi_araddr);
      next_st.rvalid = 1'b1;
      if (ri == 5'h1f) begin
        next_st.rresp = `VTP_RESP_SLVERR;
        next_st.rdata = 8'h00;
      end else if (ri == 5'(idx(`VTP_OFF_STATUS))) begin
        next_st.rresp = `VTP_RESP_OKAY;
        next_st.rdata = {4'h0, cha_gen.vsync, cha_gen.de, cha_pattern_active, chb_pattern_active};
      end else begin
        next_st.rresp = `VTP_RESP_OKAY;
        next_st.rdata = st.regs[ri];
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Leading trim of the second input, position counts received pixels
    if (second_in_de) begin
      next_st.second_pos = st.second_pos + 12'h001;
    end else begin
      next_st.second_pos = 12'h000;
    end
    next_st.second_keep = second_in_de
      && (!lr_mode || st.second_pos >= {4'h0, st.regs[idx(`VTP_OFF_SECOND_TRIM)]});
    // Trailing trim of the first input against its programmed line length
    if (first_in_de) begin
      next_st.first_pos = st.first_pos + 12'h001;
    end else begin
      next_st.first_pos = 12'h000;
    end
    next_st.first_keep = first_in_de && (!lr_mode || st.first_pos < cha_len);
  end

  // State register, all control state cleared by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

//--- bench/vtp_panel.sv
// Panel model that measures generated line and frame timing
`timescale 1ns/10ps
`default_nettype none
module vtp_panel (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Incoming video
  input wire vtp_pkg::vtp_video_t video,
  // Measured spans in clocks
  output int hs_w,
  output int hbp,
  output int act,
  output int hfp,
  output int vs_w,
  output int frame
);
  int run; // Clocks in current horizontal phase
  int vrun; // Clocks since vsync rose
  logic hs_q, de_q, vs_q; // Previous samples
  logic from_de; // Blank phase began at end of active
  // Record each span when its phase ends
  always @(posedge aclk) begin
    if (!aresetn) begin
      run <= 0;
      vrun <= 0;
      from_de <= 1'h0;
    end else begin
      run <= run + 1;
      vrun <= vrun + 1;
      if (video.hsync != hs_q || video.de != de_q) begin
        run <= 1;
        if (hs_q) hs_w <= run;
        else if (de_q) act <= run;
        else if (video.de) hbp <= run;
        // Blank lines also end in hsync, so only a gap after active counts
        else if (from_de) hfp <= run;
        from_de <= de_q;
      end
      if (video.vsync && !vs_q) begin
        frame <= vrun;
        vrun <= 1;
      end
      if (!video.vsync && vs_q) vs_w <= vrun;
    end
    hs_q <= video.hsync;
    de_q <= video.de;
    vs_q <= video.vsync;
  end
endmodule
`default_nettype wire

//--- bench/vtp_bank_sva.sv
// Port checks on the video timing bank
`timescale 1ns/10ps
`default_nettype none
module vtp_bank_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // Trim
  input wire logic first_in_de,
  input wire logic second_in_de,
  input wire logic first_keep,
  input wire logic second_keep,
  // Video and selection
  input wire vtp_pkg::vtp_video_t cha_video,
  input wire logic chb_uses_cha_timing,
  input wire logic cha_pattern_active,
  input wire logic chb_pattern_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer; s_wr_taken |=> s_axi_bvalid; endproperty
  property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_rdata_top; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  property p_sync_de; !(cha_video.hsync && cha_video.de); endproperty
  property p_back_gap; $fell(cha_video.hsync) |-> !cha_video.de; endproperty
  property p_first_keep; first_keep |-> $past(first_in_de); endproperty
  property p_second_keep; second_keep |-> $past(second_in_de); endproperty
  property p_chb_own; chb_uses_cha_timing |-> chb_pattern_active == cha_pattern_active; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_ar_refuse: assert property (p_ar_refuse) else $error("read address accepted while busy");
  a_rdata_top: assert property (p_rdata_top) else $error("upper read data not zero");
  a_sync_de: assert property (p_sync_de) else $error("hsync and de together");
  a_back_gap: assert property (p_back_gap) else $error("no back porch gap");
  a_first_keep: assert property (p_first_keep) else $error("first keep without pixel");
  a_second_keep: assert property (p_second_keep) else $error("second keep without pixel");
  a_chb_own: assert property (p_chb_own) else $error("channel B pattern differs on shared timing");
endmodule
`default_nettype wire

//--- bench/test_vtp_bank.sv
// Register, pattern and trim tests of the video timing bank
`timescale 1ns/10ps
`default_nettype none
`include "vtp_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_vtp_bank;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [8:0] s_axi_awaddr = 9'h000;
  logic [8:0] s_axi_araddr = 9'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, first_in_de = 1'h0, second_in_de = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic first_keep, second_keep, chb_uses_cha_timing, cha_pattern_active, chb_pattern_active;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  vtp_pkg::vtp_video_t cha_video, chb_video;
  int bad_count = 0, comparisons = 0, cycles = 0;
  int pa [6]; // Channel A panel measures
  int pb [6]; // Channel B panel measures
  int fa, sb; // Kept pixel counts
  // Timing tables {register, value}: channel A then channel B
  logic [15:0] cfg [21] = '{16'h4002, 16'h3403, 16'h4404, 16'h3801, 16'h3001, 16'h3100, 16'h3601,
    16'h4802, 16'h3a01, 16'h3c10, 16'h4c40, 16'h4203, 16'h3502, 16'h4603, 16'h3902, 16'h3202,
    16'h3300, 16'h3701, 16'h4a02, 16'h3b01, 16'h3c11};
  logic [7:0] mode_tab [4] = '{8'h00, 8'h20, 8'h40, 8'h10}; // Mode writes
  logic exp_share [4] = '{1'h1, 1'h1, 1'h0, 1'h0}; // Shared timing expected
  always #5 aclk = ~aclk;
  vtp_bank dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .first_in_de, .second_in_de, .first_keep, .second_keep, .cha_video, .chb_video,
    .chb_uses_cha_timing, .cha_pattern_active, .chb_pattern_active);
  vtp_panel pan_a (.aclk, .aresetn, .video(cha_video), .hs_w(pa[0]), .hbp(pa[1]), .act(pa[2]),
    .hfp(pa[3]), .vs_w(pa[4]), .frame(pa[5]));
  vtp_panel pan_b (.aclk, .aresetn, .video(chb_video), .hs_w(pb[0]), .hbp(pb[1]), .act(pb[2]),
    .hfp(pb[3]), .vs_w(pb[4]), .frame(pb[5]));
  // Register offset to byte address, four bytes per register
  function automatic logic [8:0] ba(input logic [7:0] off);
    return {off[6:0], 2'h0};
  endfunction
  // Bus write; address and data offered together, held until taken
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    `CHK(s_axi_bresp, er)
  endtask
  // Bus read; rready held until rvalid is seen
  task automatic rd(input logic [8:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    `CHK(s_axi_rdata, {24'h000000, ed})
    `CHK(s_axi_rresp, er)
  endtask
  // Five pixels on both inputs, kept pixels counted one cycle late
  task automatic pix();
    fa = 0;
    sb = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      first_in_de <= (i < 5);
      second_in_de <= (i < 5);
      if (first_keep === 1'h1) fa++;
      if (second_keep === 1'h1) sb++;
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard, far above the expected run
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      test_done();
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    for (logic [7:0] o = 8'h30; o <= 8'h3e; o++) rd(ba(o), `VTP_REG_RESET, `VTP_RESP_OKAY);
    // Fill and read back; ten-bit high parts take two bits
    for (logic [7:0] o = 8'h30; o <= 8'h3e; o++) wr(ba(o), (o[0] && o < 8'h34) ? 8'h03 : o + 8'h11, `VTP_RESP_OKAY);
    for (logic [7:0] o = 8'h30; o <= 8'h3e; o++) rd(ba(o), (o[0] && o < 8'h34) ? 8'h03 : o + 8'h11, `VTP_RESP_OKAY);
    rd(9'h0fc, 8'h00, `VTP_RESP_SLVERR);
    wr(9'h031, 8'h55, `VTP_RESP_SLVERR);
    wr(ba(`VTP_OFF_STATUS), 8'h0f, `VTP_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      wr(ba(`VTP_OFF_MODE), mode_tab[i], `VTP_RESP_OKAY);
      `CHK(chb_uses_cha_timing, exp_share[i])
    end
    for (int i = 0; i < 10; i++) wr(ba(cfg[i][15:8]), cfg[i][7:0], `VTP_RESP_OKAY);
    repeat (300) @(posedge aclk);
    `CHK(cha_pattern_active, 1'h1)
    `CHK(pa[0], 2)
    `CHK(pa[1], 3)
    `CHK(pa[2], 4)
    `CHK(pa[3], 1)
    `CHK(pa[4], 10)
    `CHK(pa[5], 50)
    for (int i = 10; i < 21; i++) wr(ba(cfg[i][15:8]), cfg[i][7:0], `VTP_RESP_OKAY);
    repeat (300) @(posedge aclk);
    `CHK(chb_pattern_active, 1'h1)
    `CHK(chb_uses_cha_timing, 1'h0)
    `CHK(pb[0], 3)
    `CHK(pb[1], 2)
    `CHK(pb[2], 3)
    `CHK(pb[3], 2)
    `CHK(pb[4], 20)
    `CHK(pb[5], 60)
    // Single link: channel B has no pattern of its own
    wr(ba(`VTP_OFF_MODE), 8'h10, `VTP_RESP_OKAY);
    `CHK(chb_pattern_active, 1'h0)
    // Left/right trim with line lengths matched to the trimmed widths
    wr(ba(`VTP_OFF_PAT_EN), 8'h00, `VTP_RESP_OKAY);
    wr(ba(`VTP_OFF_SECOND_TRIM), 8'h02, `VTP_RESP_OKAY);
    wr(ba(`VTP_OFF_FIRST_TRIM), 8'h02, `VTP_RESP_OKAY);
    wr(ba(`VTP_OFF_CHB_ACT_LO), 8'h03, `VTP_RESP_OKAY);
    wr(ba(`VTP_OFF_CHA_ACT_LO), 8'h03, `VTP_RESP_OKAY);
    wr(ba(`VTP_OFF_MODE), 8'h01, `VTP_RESP_OKAY);
    pix();
    `CHK(fa, 3)
    `CHK(sb, 3)
    wr(ba(`VTP_OFF_MODE), 8'h00, `VTP_RESP_OKAY);
    pix();
    `CHK(fa, 5)
    `CHK(sb, 5)
    test_done();
  end
endmodule
bind vtp_bank vtp_bank_sva chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .first_in_de, .second_in_de, .first_keep, .second_keep, .cha_video, .chb_uses_cha_timing,
  .cha_pattern_active, .chb_pattern_active);
`default_nettype wire
